/* hdl/mirc_regs.svh */
`ifndef MIRC_REGS_SVH
`define MIRC_REGS_SVH
// Register byte addresses on APB
`define MIRC_SECOND_OFS  12'h0000
`define MIRC_THIRD_OFS   12'h0004
`define MIRC_GLOBAL_OFS  12'h0008
`define MIRC_STATUS_OFS  12'h000C
// Field positions: flags in the high nibble, enables in the low nibble
`define MIRC_FLAG_LSB    4
`define MIRC_ENABLE_LSB  0
`define MIRC_REG_RESET   8'h00
// Mask of implemented bits in the third register on the reduced variant
`define MIRC_THIRD_REDUCED_MASK 8'h33
// Vector addresses, bit 7 of the second register first
`define MIRC_VECTOR_BASE 12'h0004
`define MIRC_VECTOR_STEP 12'h0004
`define MIRC_STACK_DEPTH 8
`endif

/* hdl/mirc_pkg.sv */
package mirc_pkg;
   typedef enum logic [1:0] {MIRC_RUN, MIRC_PUSH, MIRC_LOAD} mirc_state_t;
endpackage

/* hdl/mirc_irq_ctrl.sv */
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "mirc_regs.svh"
`default_nettype none
module mirc_irq_ctrl #(
   parameter bit HAS_COMPARATORS = 1'b1
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Peripheral events, one-cycle pulses, order matches flag bits 7..4
   input  wire logic [3:0]  second_events,
   input  wire logic [3:0]  third_events,
   // CPU core
   input  wire logic        instr_boundary,
   input  wire logic [11:0] next_pc,
   input  wire logic        return_from_irq_instr,
   input  wire logic        stack_full,
   input  wire logic        sleep_mode,
   output logic             irq_taken,
   output logic             stack_push,
   output logic [11:0]      stack_push_data,
   output logic             pc_load,
   output logic [11:0]      pc_load_addr,
   output logic             stack_pop,
   output logic             wake_up
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]  second_q;
   logic [7:0]  third_q;
   logic        global_irq_enable_q;
   logic [2:0]  pick_q;
   mirc_pkg::mirc_state_t state_q;

   logic [7:0]  third_mask;
   logic [7:0]  pending;
   logic        take;
   logic [2:0]  pick;
   logic        wr_acc;
   logic        rd_acc;
   logic [7:0]  serviced_clr;

   assign third_mask = HAS_COMPARATORS ? 8'hFF : `MIRC_THIRD_REDUCED_MASK;

   // Flag bit n is enabled by bit n-4; index 0..3 second, 4..7 third
   function automatic logic [3:0] mirc_active(input logic [7:0] r);
      mirc_active = r[7:4] & r[3:0];
   endfunction

   assign pending = {mirc_active(third_q & third_mask), mirc_active(second_q)};

   // Lowest index wins: second register bit 7 down to third bit 4
   // Scanning downwards leaves the lowest set index as the result
   function automatic logic [2:0] mirc_first(input logic [7:0] p);
      mirc_first = 3'd0;
      for (int i = 7; i >= 0; i--)
      begin
         if (p[i])
         begin
            mirc_first = 3'(i);
         end
      end
   endfunction

   // Remap so index 0 is the second register's top flag
   assign pick = mirc_first({pending[4], pending[5], pending[6], pending[7],
                             pending[0], pending[1], pending[2], pending[3]});

   // Only at a boundary, with global enable, stack room and an enabled flag
   assign take = (state_q == mirc_pkg::MIRC_RUN) && instr_boundary && global_irq_enable_q
                 && !stack_full && (pending != 8'h00);

   // Writes land at the access edge; reads are captured at setup so prdata stands in access
   assign wr_acc = psel && penable && pwrite && pready;
   assign rd_acc = psel && !penable && !pwrite;

   // One-hot of the serviced flag in {third[7:4], second[7:4]} order
   always_comb
   begin
      serviced_clr = 8'h00;
      if (take)
      begin
         // Index 0..3 maps to bits 3..0, 4..7 wraps to bits 7..4 in three bits
         serviced_clr[3'd3 - pick] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Service sequence: push, then load vector
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q <= mirc_pkg::MIRC_RUN;
         pick_q  <= 3'd0;
      end
      else
      begin
         unique case (state_q)
            mirc_pkg::MIRC_RUN:
            begin
               if (take)
               begin
                  state_q <= mirc_pkg::MIRC_PUSH;
                  pick_q  <= pick;
               end
            end
            // No new take is looked at until LOAD returns to RUN
            mirc_pkg::MIRC_PUSH: state_q <= mirc_pkg::MIRC_LOAD;
            mirc_pkg::MIRC_LOAD: state_q <= mirc_pkg::MIRC_RUN;
         endcase
      end
   end

   // Core-facing strobes, all registered
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         irq_taken       <= 1'b0;
         stack_push      <= 1'b0;
         stack_push_data <= 12'h000;
         pc_load         <= 1'b0;
         pc_load_addr    <= 12'h000;
         stack_pop       <= 1'b0;
      end
      else
      begin
         irq_taken  <= take;
         stack_push <= take;
         if (take)
         begin
            stack_push_data <= next_pc;
         end
         pc_load <= (state_q == mirc_pkg::MIRC_PUSH);
         if (state_q == mirc_pkg::MIRC_PUSH)
         begin
            pc_load_addr <= `MIRC_VECTOR_BASE + `MIRC_VECTOR_STEP * {9'h000, pick_q};
         end
         // Pop passes straight to the core stack
         stack_pop <= return_from_irq_instr;
      end
   end

   // Wake while asleep and any flag is set, enable not required
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wake_up <= 1'b0;
      end
      else
      begin
         wake_up <= sleep_mode && ((second_q[7:4] != 4'h0) || ((third_q[7:4] & third_mask[7:4]) != 4'h0));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Second register: events set over everything else
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         second_q <= `MIRC_REG_RESET;
      end
      else
      begin
         if (wr_acc && paddr == `MIRC_SECOND_OFS && pstrb[0])
         begin
            second_q <= pwdata[7:0];
         end
         else
         begin
            second_q[7:4] <= second_q[7:4] & ~serviced_clr[3:0];
         end
         second_q[7:4] <= (wr_acc && paddr == `MIRC_SECOND_OFS && pstrb[0] ? pwdata[7:4]
                          : second_q[7:4] & ~serviced_clr[3:0]) | second_events;
      end
   end

   // Third register, reduced variant keeps bits 7..6 and 3..2 at zero
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         third_q <= `MIRC_REG_RESET;
      end
      else
      begin
         if (wr_acc && paddr == `MIRC_THIRD_OFS && pstrb[0])
         begin
            third_q[3:0] <= pwdata[3:0] & third_mask[3:0];
         end
         third_q[7:4] <= ((wr_acc && paddr == `MIRC_THIRD_OFS && pstrb[0] ? pwdata[7:4]
                         : third_q[7:4] & ~serviced_clr[7:4]) | third_events) & third_mask[7:4];
      end
   end

   // Global enable: cleared on service; service wins over a same-cycle write
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         global_irq_enable_q <= 1'b0;
      end
      else if (take)
      begin
         global_irq_enable_q <= 1'b0;
      end
      else if (wr_acc && paddr == `MIRC_GLOBAL_OFS && pstrb[0])
      begin
         global_irq_enable_q <= pwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB: no wait states, read data captured in setup
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(paddr == `MIRC_SECOND_OFS || paddr == `MIRC_THIRD_OFS
                    || paddr == `MIRC_GLOBAL_OFS || paddr == `MIRC_STATUS_OFS);
         if (rd_acc)
         begin
            unique case (paddr)
               `MIRC_SECOND_OFS: prdata <= {24'h00_0000, second_q};
               `MIRC_THIRD_OFS:  prdata <= {24'h00_0000, third_q & third_mask};
               `MIRC_GLOBAL_OFS: prdata <= {31'h0000_0000, global_irq_enable_q};
               `MIRC_STATUS_OFS: prdata <= {22'h00_0000, state_q, pick_q, pending[4:0]};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Named steps of one service run, so the properties read like the walk
   sequence push_then_load_s;
      stack_push ##1 pc_load;
   endsequence

   sequence no_take_twice_s;
      !take ##1 !take;
   endsequence

   // Service run: push, load, and nothing new while it is under way
   service_sequence_a: assert property (@(posedge clk) disable iff (!resetn)
      take |=> push_then_load_s) else $error("push not followed by vector load");
   service_busy_a: assert property (@(posedge clk) disable iff (!resetn)
      take |=> no_take_twice_s) else $error("second take during a service run");
   push_value_a: assert property (@(posedge clk) disable iff (!resetn)
      take |=> stack_push_data == $past(next_pc)) else $error("wrong pc pushed");
   vector_top_a: assert property (@(posedge clk) disable iff (!resetn)
      (take && pending[3]) |-> ##2 (pc_load_addr == `MIRC_VECTOR_BASE)) else $error("top source lost priority");
   pop_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      return_from_irq_instr |=> stack_pop) else $error("return did not pop");

   // Gating: global enable, stack room and instruction boundary
   global_block_a: assert property (@(posedge clk) disable iff (!resetn)
      !global_irq_enable_q |-> !take) else $error("interrupt taken while global off");
   global_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      take |=> !global_irq_enable_q) else $error("global enable not cleared");
   stack_full_a: assert property (@(posedge clk) disable iff (!resetn)
      stack_full |-> !take) else $error("interrupt taken with full stack");
   boundary_only_a: assert property (@(posedge clk) disable iff (!resetn)
      !instr_boundary |-> !take) else $error("interrupt taken between instructions");

   // Flag storage
   disabled_stays_a: assert property (@(posedge clk) disable iff (!resetn)
      (second_q[7] && !second_q[3] && !(wr_acc && paddr == `MIRC_SECOND_OFS)) |=> second_q[7])
      else $error("disabled flag lost");
   event_sets_a: assert property (@(posedge clk) disable iff (!resetn)
      second_events[3] |=> second_q[7]) else $error("event did not set flag");
   comparator_event_a: assert property (@(posedge clk) disable iff (!resetn)
      (HAS_COMPARATORS && third_events[3]) |=> third_q[7]) else $error("comparator flag not set");
   blocked_record_a: assert property (@(posedge clk) disable iff (!resetn)
      (!global_irq_enable_q && third_events[0]) |=> third_q[4]) else $error("blocked request not recorded");
   serviced_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      (take && pending[3] && !second_events[3] && !wr_acc) |=> !second_q[7])
      else $error("serviced flag not cleared");
   reduced_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      !HAS_COMPARATORS |-> (third_q & ~`MIRC_THIRD_REDUCED_MASK) == 8'h00)
      else $error("unimplemented bits set");

   // Register writes land as written
   second_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_acc && paddr == `MIRC_SECOND_OFS && pstrb[0] && second_events == 4'h0)
      |=> second_q == $past(pwdata[7:0])) else $error("second register write lost");
   third_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_acc && paddr == `MIRC_THIRD_OFS && pstrb[0])
      |=> third_q[3:0] == ($past(pwdata[3:0]) & third_mask[3:0])) else $error("third register enables lost");
   global_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (wr_acc && paddr == `MIRC_GLOBAL_OFS && pstrb[0] && !take) |=> global_irq_enable_q == $past(pwdata[0]))
      else $error("global enable write lost");

   // Wake-up follows the flags only while asleep
   wake_a: assert property (@(posedge clk) disable iff (!resetn)
      (sleep_mode && second_q[4]) |=> wake_up) else $error("no wake on flag");
   wake_sleep_a: assert property (@(posedge clk) disable iff (!resetn)
      wake_up |-> $past(sleep_mode)) else $error("wake raised while awake");

endmodule
`default_nettype wire

/* tb/mirc_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mirc_regs.svh"
module mirc_cpu_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Requests from the controller
   input  wire logic        stack_push,
   input  wire logic [11:0] stack_push_data,
   input  wire logic        pc_load,
   input  wire logic [11:0] pc_load_addr,
   input  wire logic        stack_pop,
   // Core state
   output logic      [11:0] next_pc,
   output logic             stack_full
);
   logic [11:0] stack_q [8];
   logic [3:0]  sp_q;
   ////////////////////////////////////////////////////////////
   // Counter stands still between vectors, so every push value is predictable
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sp_q    <= 4'h0;
         next_pc <= 12'h100;
      end
      else
      begin
         if (stack_push)
         begin
            stack_q[sp_q[2:0]] <= stack_push_data;
            sp_q               <= sp_q + 4'h1;
         end
         if (pc_load)
            next_pc <= pc_load_addr;
         if (stack_pop)
         begin
            sp_q    <= sp_q - 4'h1;
            next_pc <= stack_q[sp_q[2:0] - 3'h1];
         end
      end
   end
   // A push while full is never asked for, so no overflow guard
   assign stack_full = (sp_q == 4'(`MIRC_STACK_DEPTH));
endmodule
`default_nettype wire

/* tb/mcu_interrupt_request_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mirc_regs.svh"
module mcu_interrupt_request_control_bench;
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err, irq_taken, stack_push, pc_load;
   logic        stack_pop, wake_up, instr_boundary, return_from_irq_instr, stack_full, sleep_mode;
   logic [3:0]  pstrb, second_events, third_events;
   logic [11:0] paddr, next_pc, stack_push_data, pc_load_addr;
   logic [31:0] pwdata, prdata, prdata_b, rd, rd_b;
   int          fail_count = 0, checks = 0, cycles = 0;
   ////////////////////////////////////////////////////////////
   // Full variant under test, reduced variant only read back
   mirc_irq_ctrl u_mirc_irq_ctrl (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .second_events, .third_events, .instr_boundary, .next_pc, .return_from_irq_instr,
      .stack_full, .sleep_mode, .irq_taken, .stack_push, .stack_push_data, .pc_load, .pc_load_addr,
      .stack_pop, .wake_up);
   mirc_irq_ctrl #(.HAS_COMPARATORS(1'b0)) u_mirc_irq_ctrl_reduced (.clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata(prdata_b), .pready(), .pslverr(), .second_events, .third_events,
      .instr_boundary, .next_pc, .return_from_irq_instr, .stack_full, .sleep_mode, .irq_taken(),
      .stack_push(), .stack_push_data(), .pc_load(), .pc_load_addr(), .stack_pop(), .wake_up());
   mirc_cpu_model u_mirc_cpu_model (.clk, .resetn, .stack_push, .stack_push_data, .pc_load, .pc_load_addr,
      .stack_pop, .next_pc, .stack_full);
   ////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      if (seen !== exp)
         fail_count++;
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One transfer; request held until pready is seen at an edge, then one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      ok      = 1'b0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Registered answers are read mid-cycle, settled, then the edge that samples them ends the access
      while (!ok)
      begin
         @(negedge clk);
         ok   = (pready === 1'b1);
         rd   = prdata;
         rd_b = prdata_b;
         err  = pslverr;
         @(posedge clk);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask
   task automatic pulse(input logic [3:0] s, input logic [3:0] t);
      second_events <= s;
      third_events  <= t;
      @(posedge clk);
      second_events <= 4'h0;
      third_events  <= 4'h0;
      @(posedge clk);
   endtask
   // Long enough to catch a take that must not happen
   task automatic no_take();
      logic seen;
      seen = 1'b0;
      repeat (12)
      begin
         @(posedge clk);
         seen |= irq_taken;
      end
      check(32'(seen), 32'h0000_0000);
   endtask
   task automatic take(input logic [11:0] push, input logic [11:0] vec);
      int n;
      n = 0;
      // Strobes are looked at mid-cycle, where they stand settled
      @(negedge clk);
      while (irq_taken !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      check(32'({stack_push, stack_push_data}), 32'({1'b1, push}));
      @(negedge clk);
      check(32'({pc_load, pc_load_addr}), 32'({1'b1, vec}));
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      {resetn, psel, penable, pwrite, return_from_irq_instr} = 5'h00;
      paddr          = 12'h000;
      pwdata         = 32'h0000_0000;
      pstrb          = 4'hF;
      second_events  = 4'h0;
      third_events   = 4'h0;
      instr_boundary = 1'b1;
      sleep_mode     = 1'b1;
      repeat (4)
         @(posedge clk);
      resetn <= 1'b1;
      rchk(`MIRC_SECOND_OFS, 32'h0000_0000);
      rchk(`MIRC_THIRD_OFS, 32'h0000_0000);
      check(32'(wake_up), 32'h0000_0000);
      rchk(12'h010, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      // Flags writable too; the reduced third register keeps frame and serial only
      apb(1'b1, `MIRC_SECOND_OFS, 32'h0000_00A5);
      rchk(`MIRC_SECOND_OFS, 32'h0000_00A5);
      check(32'(wake_up), 32'h0000_0001);
      apb(1'b1, `MIRC_THIRD_OFS, 32'h0000_00FF);
      rchk(`MIRC_THIRD_OFS, 32'h0000_00FF);
      check(rd_b, 32'h0000_0033);
      no_take();
      apb(1'b1, `MIRC_SECOND_OFS, 32'h0000_0000);
      apb(1'b1, `MIRC_THIRD_OFS, 32'h0000_0000);
      pulse(4'hF, 4'hF);
      rchk(`MIRC_SECOND_OFS, 32'h0000_00F0);
      rchk(`MIRC_THIRD_OFS, 32'h0000_00F0);
      apb(1'b1, `MIRC_GLOBAL_OFS, 32'h0000_0001);
      no_take();
      instr_boundary <= 1'b0;
      apb(1'b1, `MIRC_SECOND_OFS, 32'h0000_00FF);
      apb(1'b1, `MIRC_THIRD_OFS, 32'h0000_00FF);
      no_take();
      instr_boundary <= 1'b1;
      // Nested takes in priority order until the stack is full
      for (int k = 0; k < 8; k++)
      begin
         if (k > 0)
            apb(1'b1, `MIRC_GLOBAL_OFS, 32'h0000_0001);
         take((k == 0) ? 12'h100 : 12'(4 * k), 12'(4 + 4 * k));
         if (k == 0)
            rchk(`MIRC_GLOBAL_OFS, 32'h0000_0000);
         if (k == 0)
            rchk(`MIRC_SECOND_OFS, 32'h0000_007F);
      end
      pulse(4'h8, 4'h0);
      apb(1'b1, `MIRC_GLOBAL_OFS, 32'h0000_0001);
      no_take();
      return_from_irq_instr <= 1'b1;
      @(posedge clk);
      return_from_irq_instr <= 1'b0;
      repeat (2)
         @(posedge clk);
      check(32'(next_pc), 32'h0000_001C);
      take(12'h01C, 12'h004);
      pulse(4'h0, 4'h1);
      rchk(`MIRC_THIRD_OFS, 32'h0000_001F);
      report_and_stop();
   end
endmodule
`default_nettype wire
